// *** shared/position_word_params.svh ***
// Purpose: Register map, field positions and fixed widths of the position word generator
// Assumes: Byte-wide register port, byte addresses as listed here
// Notes:   Definitions only
`ifndef POSITION_WORD_PARAMS_SVH
`define POSITION_WORD_PARAMS_SVH

// Register byte addresses
`define ADDR_SPLIT_DIR   8'h1b
`define ADDR_FINE_OFF_B1 8'h1c
`define ADDR_FINE_OFF_B2 8'h1d
`define ADDR_FINE_OFF_B3 8'h1e
`define ADDR_TURN_OFF_B0 8'h1f
`define ADDR_TURN_OFF_B1 8'h20
`define ADDR_TURN_OFF_B2 8'h21
`define ADDR_RESO        8'h24
`define ADDR_STATUS      8'h25

// Field positions
`define SPLIT_MSB        1
`define SPLIT_LSB        0
`define DIR_BIT          2
`define FINE_OFF_LO_MSB  7
`define FINE_OFF_LO_LSB  6
`define TURN_WIDTH_MSB   7
`define TURN_WIDTH_LSB   5
`define FINE_WIDTH_MSB   4
`define FINE_WIDTH_LSB   0
`define STAT_QUAD_MSB    1
`define STAT_QUAD_LSB    0
`define STAT_CORR_BIT    2
`define STAT_BUSY_BIT    3

// Fixed widths
`define CNT_BITS_MAX     37
`define IPO_BITS         13
`define MT_BITS          24
`define MT_PAR_STEP      4
`define MT_SENSOR_SHORT  12

// Field codes
`define MT_SEL_NONE      3'h6
`define MT_SEL_SENSOR_12 3'h3
`define STEP_UP          2'h1
`define STEP_DOWN        2'h3
`define STEP_FAR         2'h2

// Reset values
`define RST_SPLIT        2'h0
`define RST_DIR          1'b0
`define RST_FINE_OFF     26'h0000000
`define RST_TURN_OFF     24'h000000
`define RST_MT_SEL       3'h0
`define RST_ST_SEL       5'h00

`endif

// *** shared/position_word_pkg.sv ***
// Purpose: Types shared by the position word generator modules
// Assumes: Nothing beyond the header of constants
// Notes:   Pipeline states are Gray coded along their only path
`default_nettype none
package position_word_pkg;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_SYNC = 2'b01,
    S_OFFS = 2'b11,
    S_EMIT = 2'b10
  } pipe_state_t;

  typedef logic [1:0] quadrant_t;
  typedef logic [1:0] split_t;
  typedef logic [2:0] mt_sel_t;
  typedef logic [4:0] st_sel_t;

endpackage
`default_nettype wire

// *** shared/count_if.sv ***
// Purpose: Carries the running quarter-period count to the word builder
// Assumes: One clock domain on both ends
// Notes:   Count holds periods above two quadrant bits
`timescale 1ns/1ps
`default_nettype none
interface count_if
  import position_word_pkg::*;
#(
  parameter int CNT_W = 37
) ();
  logic [CNT_W+1:0] quarters;
  quadrant_t        quadrant;

  modport source (output quarters, output quadrant);
  modport sink   (input quarters, input quadrant);
endinterface
`default_nettype wire

// *** core/period_counter.sv ***
// Purpose: Free-running period counter driven by the sine and cosine sign comparators
// Assumes: Comparator signs are synchronous to clk_i
// Notes:   Counts quadrants; the upper bits are the period count
`timescale 1ns/1ps
`default_nettype none
`include "position_word_params.svh"
module period_counter
  import position_word_pkg::*;
#(
  parameter int CNT_W = `CNT_BITS_MAX
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  // Comparator signs
  input  wire logic sin_pos_i,
  input  wire logic cos_pos_i,
  // Count toward the word builder
  count_if.source   cnt
);

  localparam int QW = CNT_W + 2;

  function automatic quadrant_t quadrant_of(input logic s, input logic c);
    return {~s, s ^ c};
  endfunction

  quadrant_t     q_now;
  quadrant_t     q_reg;
  quadrant_t     q_step;
  logic          primed_reg;
  logic [QW-1:0] quarters_reg;

  assign q_now  = quadrant_of(sin_pos_i, cos_pos_i);
  assign q_step = q_now - q_reg;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q_reg      <= 2'h0;
      primed_reg <= 1'b0;
    end else begin
      q_reg      <= q_now;
      primed_reg <= 1'b1;
    end
  end

  // First sample after reset only seeds the quadrant; a two-quadrant jump is ambiguous
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      quarters_reg <= '0;
    end else if (primed_reg && q_step == `STEP_UP) begin
      quarters_reg <= quarters_reg + QW'(1);
    end else if (primed_reg && q_step == `STEP_DOWN) begin
      quarters_reg <= quarters_reg - QW'(1);
    end
  end

  assign cnt.quarters = quarters_reg;
  assign cnt.quadrant = q_reg;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_step_up;
    primed_reg && q_step == `STEP_UP |=> quarters_reg == $past(quarters_reg) + QW'(1);
  endproperty
  a_step_up: assert property (p_step_up)
    else $error("period count missed an up step");

  property p_step_down;
    primed_reg && q_step == `STEP_DOWN |=> quarters_reg == $past(quarters_reg) - QW'(1);
  endproperty
  a_step_down: assert property (p_step_down)
    else $error("period count missed a down step");

  property p_hold;
    q_now == q_reg ##1 q_now == q_reg |-> $stable(quarters_reg);
  endproperty
  a_hold: assert property (p_hold)
    else $error("period count moved without a quadrant change");

endmodule
`default_nettype wire

// *** core/mt_width_limiter.sv ***
// Purpose: Cuts the multiturn value to the width selected for each output class
// Assumes: Input is right aligned
// Notes:   Purely combinational; the clock only serves the checks
`timescale 1ns/1ps
`default_nettype none
`include "position_word_params.svh"
module mt_width_limiter
  import position_word_pkg::*;
#(
  parameter int MT_W = `MT_BITS
) (
  // Clock and reset for checks
  input  wire logic            clk_i,
  input  wire logic            reset_n_i,
  // Multiturn value and width select
  input  wire logic [MT_W-1:0] mt_i,
  input  wire mt_sel_t         sel_i,
  // Reduced values
  output logic      [MT_W-1:0] par_o,
  output logic      [MT_W-1:0] sensor_o
);

  if (MT_W != `MT_BITS) begin : g_bad_width
    $error("mt_width_limiter serves only the fixed multiturn width");
  end

  function automatic int unsigned par_bits(input mt_sel_t s);
    return (s >= `MT_SEL_NONE) ? 0 : MT_W - `MT_PAR_STEP * int'(s);
  endfunction

  function automatic int unsigned sensor_bits(input mt_sel_t s);
    if (s >= `MT_SEL_NONE) return 0;
    if (s >= `MT_SEL_SENSOR_12) return `MT_SENSOR_SHORT;
    return MT_W;
  endfunction

  function automatic logic [MT_W-1:0] keep_low(input logic [MT_W-1:0] v, input int unsigned n);
    logic [MT_W-1:0] m;
    m = '0;
    for (int i = 0; i < MT_W; i++) begin
      m[i] = (i < n);
    end
    return v & m;
  endfunction

  // Right aligned, upper bits forced to zero
  assign par_o    = keep_low(mt_i, par_bits(sel_i));
  assign sensor_o = keep_low(mt_i, sensor_bits(sel_i));

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_par_none;
    sel_i >= `MT_SEL_NONE |-> par_o == '0 && sensor_o == '0;
  endproperty
  a_par_none: assert property (p_par_none)
    else $error("multiturn not empty for width code six or seven");

  property p_par_align;
    par_o == ((mt_i << (MT_W - par_bits(sel_i))) >> (MT_W - par_bits(sel_i)));
  endproperty
  a_par_align: assert property (p_par_align)
    else $error("parallel multiturn not right aligned with zero top");

  property p_sensor_short;
    sel_i >= `MT_SEL_SENSOR_12 && sel_i < `MT_SEL_NONE |->
      sensor_o == ((mt_i << (MT_W - `MT_SENSOR_SHORT)) >> (MT_W - `MT_SENSOR_SHORT));
  endproperty
  a_sensor_short: assert property (p_sensor_short)
    else $error("sensor multiturn not cut to twelve bits");

endmodule
`default_nettype wire

// *** core/position_word_generator.sv ***
// Purpose: Builds the absolute position word from period count and interpolation value
// Assumes: Analog path delivers comparator signs and a 13-bit value beside each request
// Notes:   Word appears three cycles after the request edge; requests while busy are dropped
`timescale 1ns/1ps
`default_nettype none
`include "position_word_params.svh"
module position_word_generator
  import position_word_pkg::*;
#(
  parameter int CNT_W = `CNT_BITS_MAX,
  parameter int IPO_W = `IPO_BITS,
  parameter int MT_W  = `MT_BITS
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  // Register port
  input  wire logic [7:0]        reg_addr_i,
  input  wire logic [7:0]        reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [7:0]        reg_rdata_o,
  // Conditioned analog path
  input  wire logic              sin_pos_i,
  input  wire logic              cos_pos_i,
  input  wire logic [IPO_W-1:0]  ipo_value_i,
  input  wire logic              pos_request_i,
  // Position toward the output interfaces
  output logic                   pos_valid_o,
  output logic                   busy_o,
  output logic      [MT_W-1:0]   mt_par_o,
  output logic      [25:0]       st_par_o,
  output logic      [MT_W-1:0]   mt_sensor_o,
  output logic      [11:0]       mt_ssi_long_o
);

  localparam int WORD_W = CNT_W + IPO_W;
  localparam int ST_W   = WORD_W - MT_W;
  localparam int QW     = CNT_W + 2;

  if (CNT_W != `CNT_BITS_MAX || IPO_W != `IPO_BITS || MT_W != `MT_BITS) begin : g_bad_cfg
    $error("position_word_generator serves only the fixed word layout");
  end

  function automatic logic [WORD_W-1:0] low_mask(input int unsigned n);
    logic [WORD_W-1:0] m;
    m = '0;
    for (int i = 0; i < WORD_W; i++) begin
      m[i] = (i < n);
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  split_t          split_reg;
  logic            dir_reg;
  logic [ST_W-1:0] fine_off_reg;
  logic [MT_W-1:0] turn_off_reg;
  mt_sel_t         mt_sel_reg;
  st_sel_t         st_sel_reg;
  logic [7:0]      rdata_reg;
  logic [7:0]      rdata_next;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      split_reg  <= `RST_SPLIT;
      dir_reg    <= `RST_DIR;
      fine_off_reg <= `RST_FINE_OFF;
      turn_off_reg <= `RST_TURN_OFF;
      mt_sel_reg <= `RST_MT_SEL;
      st_sel_reg <= `RST_ST_SEL;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        `ADDR_SPLIT_DIR: begin
          split_reg      <= reg_wdata_i[`SPLIT_MSB:`SPLIT_LSB];
          dir_reg        <= reg_wdata_i[`DIR_BIT];
          fine_off_reg[1:0] <= reg_wdata_i[`FINE_OFF_LO_MSB:`FINE_OFF_LO_LSB];
        end
        `ADDR_FINE_OFF_B1: begin
          fine_off_reg[9:2] <= reg_wdata_i;
        end
        `ADDR_FINE_OFF_B2: begin
          fine_off_reg[17:10] <= reg_wdata_i;
        end
        `ADDR_FINE_OFF_B3: begin
          fine_off_reg[25:18] <= reg_wdata_i;
        end
        `ADDR_TURN_OFF_B0: begin
          turn_off_reg[7:0] <= reg_wdata_i;
        end
        `ADDR_TURN_OFF_B1: begin
          turn_off_reg[15:8] <= reg_wdata_i;
        end
        `ADDR_TURN_OFF_B2: begin
          turn_off_reg[23:16] <= reg_wdata_i;
        end
        `ADDR_RESO: begin
          mt_sel_reg <= reg_wdata_i[`TURN_WIDTH_MSB:`TURN_WIDTH_LSB];
          st_sel_reg <= reg_wdata_i[`FINE_WIDTH_MSB:`FINE_WIDTH_LSB];
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register read: data stand only in the cycle after the strobe

  count_if #(.CNT_W(CNT_W)) count_bus ();
  pipe_state_t state_reg;
  logic        corrected_reg;
  logic        busy_reg;

  always_comb begin
    rdata_next = 8'h00;
    unique case (reg_addr_i)
      `ADDR_SPLIT_DIR: begin
        rdata_next[`SPLIT_MSB:`SPLIT_LSB]       = split_reg;
        rdata_next[`DIR_BIT]                    = dir_reg;
        rdata_next[`FINE_OFF_LO_MSB:`FINE_OFF_LO_LSB] = fine_off_reg[1:0];
      end
      `ADDR_FINE_OFF_B1: rdata_next = fine_off_reg[9:2];
      `ADDR_FINE_OFF_B2: rdata_next = fine_off_reg[17:10];
      `ADDR_FINE_OFF_B3: rdata_next = fine_off_reg[25:18];
      `ADDR_TURN_OFF_B0: rdata_next = turn_off_reg[7:0];
      `ADDR_TURN_OFF_B1: rdata_next = turn_off_reg[15:8];
      `ADDR_TURN_OFF_B2: rdata_next = turn_off_reg[23:16];
      `ADDR_RESO: begin
        rdata_next[`TURN_WIDTH_MSB:`TURN_WIDTH_LSB] = mt_sel_reg;
        rdata_next[`FINE_WIDTH_MSB:`FINE_WIDTH_LSB] = st_sel_reg;
      end
      `ADDR_STATUS: begin
        rdata_next[`STAT_QUAD_MSB:`STAT_QUAD_LSB] = count_bus.quadrant;
        rdata_next[`STAT_CORR_BIT]                = corrected_reg;
        rdata_next[`STAT_BUSY_BIT]                = busy_reg;
      end
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= reg_rd_i ? rdata_next : 8'h00;
    end
  end

  assign reg_rdata_o = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Period counter

  period_counter #(.CNT_W(CNT_W)) u_counter (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .sin_pos_i (sin_pos_i),
    .cos_pos_i (cos_pos_i),
    .cnt       (count_bus.source)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Word pipeline datapath

  logic [QW-1:0]     snap_q_reg;
  logic [IPO_W-1:0]  ipo_reg;
  logic [WORD_W-1:0] full_reg;
  logic [MT_W-1:0]   mt_adj_reg;
  logic [ST_W-1:0]   st_al_reg;
  logic [1:0]        sync_delta;
  logic [QW-1:0]     adj_q;
  logic [WORD_W-1:0] active_mask;
  logic [WORD_W-1:0] full_raw;
  logic [WORD_W-1:0] full_dir;
  logic [WORD_W-1:0] st_mask;
  logic [WORD_W-1:0] mt_shift;
  logic [MT_W-1:0]   mt_raw;
  logic [ST_W-1:0]   st_raw;
  logic [ST_W-1:0]   st_diff;
  logic [WORD_W-1:0] st_cut_mask;
  logic [MT_W-1:0]   mt_par_w;
  logic [MT_W-1:0]   mt_sensor_w;
  int unsigned       split_n;
  int unsigned       st_cut;

  assign split_n = int'(split_reg);

  // Counter may have moved a quadrant past the sample; the interpolator's quadrant wins
  assign sync_delta = ipo_reg[IPO_W-1 -: 2] - snap_q_reg[1:0];

  always_comb begin
    if (sync_delta == `STEP_UP) begin
      adj_q = snap_q_reg + QW'(1);
    end else if (sync_delta == `STEP_DOWN) begin
      adj_q = snap_q_reg - QW'(1);
    end else begin
      adj_q = snap_q_reg;
    end
  end

  // Split code trims the counter's top bits, interpolation stays in place
  assign active_mask = low_mask(WORD_W - split_n);
  assign full_raw    = {adj_q[QW-1:2], ipo_reg} & active_mask;
  assign full_dir    = dir_reg ? (~full_raw & active_mask) : full_raw;

  assign st_mask  = low_mask(ST_W - split_n);
  assign mt_shift = full_reg >> (ST_W - split_n);
  assign mt_raw   = mt_shift[MT_W-1:0];
  assign st_raw   = full_reg[ST_W-1:0] & st_mask[ST_W-1:0];
  assign st_diff  = (st_raw - fine_off_reg) & st_mask[ST_W-1:0];

  // Singleturn cut from the bottom so it stays left aligned
  assign st_cut      = (int'(st_sel_reg) > ST_W) ? ST_W : int'(st_sel_reg);
  assign st_cut_mask = low_mask(st_cut);

  mt_width_limiter #(.MT_W(MT_W)) u_limiter (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .mt_i      (mt_adj_reg),
    .sel_i     (mt_sel_reg),
    .par_o     (mt_par_w),
    .sensor_o  (mt_sensor_w)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Pipeline control

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= S_IDLE;
      busy_reg  <= 1'b0;
    end else begin
      unique case (state_reg)
        S_IDLE: begin
          if (pos_request_i) begin
            state_reg <= S_SYNC;
            busy_reg  <= 1'b1;
          end
        end
        S_SYNC: state_reg <= S_OFFS;
        S_OFFS: state_reg <= S_EMIT;
        S_EMIT: begin
          state_reg <= S_IDLE;
          busy_reg  <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      snap_q_reg    <= '0;
      ipo_reg       <= '0;
      full_reg      <= '0;
      mt_adj_reg    <= '0;
      st_al_reg     <= '0;
      corrected_reg <= 1'b0;
    end else begin
      if (state_reg == S_IDLE && pos_request_i) begin
        snap_q_reg <= count_bus.quarters;
        ipo_reg    <= ipo_value_i;
      end
      if (state_reg == S_SYNC) begin
        full_reg      <= full_dir;
        corrected_reg <= (adj_q != snap_q_reg);
      end
      if (state_reg == S_OFFS) begin
        mt_adj_reg <= mt_raw - turn_off_reg;
        st_al_reg  <= st_diff << split_n;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output registers, position held until the next word, valid pulsed for one cycle

  logic            valid_reg;
  logic [MT_W-1:0] mt_par_reg;
  logic [ST_W-1:0] st_par_reg;
  logic [MT_W-1:0] mt_sensor_reg;
  logic [11:0]     mt_ssi_reg;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      valid_reg     <= 1'b0;
      mt_par_reg    <= '0;
      st_par_reg    <= '0;
      mt_sensor_reg <= '0;
      mt_ssi_reg    <= 12'h000;
    end else begin
      valid_reg <= (state_reg == S_EMIT);
      if (state_reg == S_EMIT) begin
        mt_par_reg    <= mt_par_w;
        st_par_reg    <= st_al_reg & ~st_cut_mask[ST_W-1:0];
        mt_sensor_reg <= mt_sensor_w;
        mt_ssi_reg    <= mt_adj_reg[`MT_SENSOR_SHORT-1:0];
      end
    end
  end

  assign pos_valid_o   = valid_reg;
  assign busy_o        = busy_reg;
  assign mt_par_o      = mt_par_reg;
  assign st_par_o      = st_par_reg;
  assign mt_sensor_o   = mt_sensor_reg;
  assign mt_ssi_long_o = mt_ssi_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks; config writes during a conversion can trip the layout checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_latency;
    state_reg == S_IDLE && pos_request_i |=> busy_o [*3] ##1 (pos_valid_o && !busy_o);
  endproperty
  a_latency: assert property (p_latency)
    else $error("position word not delivered three cycles after request");

  property p_sync_quadrant;
    state_reg == S_SYNC && sync_delta != `STEP_FAR |-> adj_q[1:0] == ipo_reg[IPO_W-1 -: 2];
  endproperty
  a_sync_quadrant: assert property (p_sync_quadrant)
    else $error("period count not aligned to interpolation quadrant");

  property p_split_top;
    state_reg == S_OFFS |-> (full_reg >> (WORD_W - split_n)) == '0;
  endproperty
  a_split_top: assert property (p_split_top)
    else $error("counter bits above the split width not zero");

  property p_mt_offset;
    state_reg == S_OFFS |=> mt_adj_reg == MT_W'($past(mt_raw) - $past(turn_off_reg));
  endproperty
  a_mt_offset: assert property (p_mt_offset)
    else $error("multiturn offset not subtracted");

  property p_st_left;
    state_reg == S_EMIT |-> ({{MT_W{1'b0}}, st_al_reg} & low_mask(split_n)) == '0;
  endproperty
  a_st_left: assert property (p_st_left)
    else $error("singleturn not left aligned");

  c_request:   cover property (state_reg == S_IDLE && pos_request_i);
  c_inverted:  cover property (pos_valid_o && dir_reg);
  c_corrected: cover property (state_reg == S_SYNC && sync_delta != 2'h0);

endmodule
`default_nettype wire

// *** verification/pos_sink.sv ***
// Purpose: Output interface side, latches each finished position word
// Assumes: pos_valid_o is a one-cycle pulse
// Notes:   Counts words so that a dropped request shows as a missing word
`timescale 1ns/1ps
`default_nettype none
module pos_sink (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // Word from the generator
  input  wire logic        valid_i,
  input  wire logic [85:0] word_i,
  // Captured word
  output var  logic [85:0] word_o,
  output var  logic [15:0] count_o
);
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      word_o  <= '0;
      count_o <= '0;
    end else if (valid_i) begin
      word_o  <= word_i;
      count_o <= count_o + 16'h1;
    end
  end
endmodule
`default_nettype wire

// *** verification/tb_position_word_generator.sv ***
// Purpose: Self-checking bench of the position word generator
// Assumes: Quadrant inputs stay put while a conversion runs
// Notes:   Interpolation quadrant set one step off at random to drive the count correction
`timescale 1ns/1ps
`default_nettype none
`include "position_word_params.svh"
module tb_position_word_generator;
  logic        clk_i = 0, reset_n_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic        sin_pos_i = 1, cos_pos_i = 1, pos_request_i = 0;
  logic [7:0]  reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o;
  logic [12:0] ipo_value_i = 0;
  logic        pos_valid_o, busy_o;
  logic [23:0] mt_par_o, mt_sensor_o;
  logic [25:0] st_par_o;
  logic [11:0] mt_ssi_long_o;
  logic [85:0] got;
  logic [15:0] words;
  logic [31:0] seed = 32'h0000426f;
  logic [38:0] qc = 0;
  int          err_count = 0;
  int          comparisons = 0;

  always #2.5 clk_i = ~clk_i;

  position_word_generator i_position_word_generator (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .sin_pos_i(sin_pos_i),
    .cos_pos_i(cos_pos_i), .ipo_value_i(ipo_value_i), .pos_request_i(pos_request_i),
    .pos_valid_o(pos_valid_o), .busy_o(busy_o), .mt_par_o(mt_par_o), .st_par_o(st_par_o),
    .mt_sensor_o(mt_sensor_o), .mt_ssi_long_o(mt_ssi_long_o));
  pos_sink i_pos_sink (.clk_i(clk_i), .reset_n_i(reset_n_i), .valid_i(pos_valid_o),
    .word_i({mt_par_o, st_par_o, mt_sensor_o, mt_ssi_long_o}), .word_o(got), .count_o(words));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [85:0] expect_word(input logic [38:0] q, input logic [12:0] ipo,
    input logic [1:0] s, input logic d, input logic [25:0] so, input logic [23:0] mo,
    input logic [2:0] mc, input logic [4:0] sc);
    logic [49:0] w;
    logic [23:0] mt, par, sen;
    logic [26:0] st, m;
    w = {q[38:2], ipo};
    if (d) w = ~w;
    mt = 24'(w >> (26 - s)) - mo;
    m = (27'h1 << (26 - s)) - 27'h1;
    st = (27'(w) - 27'(so)) & m;
    st = (st << s) & ~((27'h1 << (sc > 26 ? 26 : sc)) - 27'h1);
    par = (mc > 5) ? 24'h0 : mt & 24'((25'h1 << (24 - 4 * mc)) - 25'h1);
    sen = (mc < 3) ? mt : (mc < 6) ? {12'h0, mt[11:0]} : 24'h0;
    return {par, st[25:0], sen, mt[11:0]};
  endfunction

  task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %0t byte got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_pos(input logic [85:0] g, input logic [85:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %0t word got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_i);
    reg_rd_i   <= 1'b0;
    #1 v = reg_rdata_o;
  endtask

  // One quadrant step, then time for the comparator path to settle
  task automatic step(input logic up);
    qc = up ? qc + 39'h1 : qc - 39'h1;
    @(posedge clk_i);
    sin_pos_i <= ~qc[1];
    cos_pos_i <= ~^qc[1:0];
    repeat (2) @(posedge clk_i);
  endtask

  task automatic close_out();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #400000;
    err_count++;
    close_out();
  end

  initial begin
    logic [7:0]  b;
    logic [31:0] r, v;
    logic [25:0] so;
    logic [23:0] mo;
    logic [12:0] ipo;
    logic [1:0]  d;
    logic [38:0] qe;
    int          k;
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'b1;
    for (int a = 8'h1b; a <= 8'h26; a++) begin
      rd(8'(a), b);
      chk_reg(b, 8'h00);
    end
    for (int t = 0; t < 160; t++) begin
      r = rnd();
      repeat (r[3:0]) step(r[31]);
      so = 26'(rnd());
      mo = 24'(rnd());
      if (t < 8) begin
        so = '0;
        mo = '0;
      end
      v = rnd();
      wr(`ADDR_SPLIT_DIR, {so[1:0], 3'h0, r[6:4]});
      wr(`ADDR_FINE_OFF_B1, so[9:2]);
      wr(`ADDR_FINE_OFF_B2, so[17:10]);
      wr(`ADDR_FINE_OFF_B3, so[25:18]);
      wr(`ADDR_TURN_OFF_B0, mo[7:0]);
      wr(`ADDR_TURN_OFF_B1, mo[15:8]);
      wr(`ADDR_TURN_OFF_B2, mo[23:16]);
      wr(`ADDR_RESO, {t[2:0], v[16:12]});
      rd(`ADDR_RESO, b);
      chk_reg(b, {t[2:0], v[16:12]});
      rd(`ADDR_SPLIT_DIR, b);
      chk_reg(b, {so[1:0], 3'h0, r[6:4]});
      rd(`ADDR_TURN_OFF_B2, b);
      chk_reg(b, mo[23:16]);
      rd(`ADDR_STATUS, b);
      chk_reg(b & 8'h03, {6'h0, qc[1:0]});
      // Interpolator a quadrant ahead, behind or level at random: the period count must follow it
      d   = v[17] ? {v[18], 1'b1} : 2'h0;
      ipo = {qc[1:0] + d, v[10:0]};
      qe  = qc + {{37{d[1]}}, d};
      @(posedge clk_i);
      pos_request_i <= 1'b1;
      ipo_value_i   <= ipo;
      // Odd tests hold the request a second cycle, which must be dropped
      @(posedge clk_i);
      pos_request_i <= t[0];
      #1 chk_reg({7'h0, busy_o}, 8'h01);
      @(posedge clk_i);
      pos_request_i <= 1'b0;
      k = 0;
      #1;
      while (pos_valid_o !== 1'b1 && k < 10) begin
        @(posedge clk_i);
        #1 k++;
      end
      chk_reg(8'(k), 8'h02);
      @(posedge clk_i);
      #1 chk_pos(got, expect_word(qe, ipo, r[5:4], r[6], so, mo, t[2:0],
                                  v[16:12]));
      chk_reg(words[7:0], 8'(t + 1));
      rd(`ADDR_STATUS, b);
      chk_reg(b, {4'h0, 1'b0, d != 2'h0, qc[1:0]});
      $display("test %0d done", t);
    end
    close_out();
  end
endmodule
`default_nettype wire
